// ===== bit_clear_cond_branch_exec.sv
/*
  Decode and execute of the bit clear and the two conditional branches
  (negative, no carry) on the four-phase instruction cycle.
  Assumes the fetch unit offers a word at Q1, data memory answers a read
  issued in Q2 one clock later, and flags come from the same clock domain.
*/
// Function
// - bit clear zeroes one bit, keeps others
// - access bit zero selects the access bank
// - access bit one uses bank select register
// - extended set, offset up to 5Fh indexed
// - negative branch jumps only when negative set
// - no-carry branch jumps on clear carry, flags untouched
// - target is own address plus 2 plus 2n
// - taken branch adds one discarded no-operation cycle
`timescale 1ns/1ns
module bit_clear_cond_branch_exec
  import core_exec_pkg::*;
#(
  parameter int PC_W = 21,
  parameter int ADDR_W = 12
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_instr_valid,
  input wire logic [15:0] i_instr,
  input wire logic [PC_W-1:0] i_instr_pc,
  input wire logic [3:0] i_bank_select_register,
  input wire logic i_ext_set_en,
  input wire logic [ADDR_W-1:0] i_index_base,
  input wire logic i_negative,
  input wire logic i_carry,
  input wire logic [7:0] i_mem_rdata,
  output logic o_instr_ready,
  output logic o_discard,
  output logic o_mem_rd,
  output logic o_mem_wr,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_pc_load,
  output logic [PC_W-1:0] o_pc_target
);

  phase_type phase;
  kind_type kind_r, kind_nxt;
  logic [15:0] instr_r, instr_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [PC_W-1:0] target_r, target_nxt;
  logic taken_r, taken_nxt;
  logic nop_r, nop_nxt;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // data address of a file-register operand; used at decode only
  function automatic logic [ADDR_W-1:0] resolve_addr(input logic [15:0] ins,
                                                      input logic [3:0] bank,
                                                      input logic ext_en,
                                                      input logic [ADDR_W-1:0] base);
    logic [7:0] f;
    f = ins[7:0];
    resolve_addr = '0;
    if (ins[ACCESS_BIT_POS]) begin
      resolve_addr = ADDR_W'({bank, f});
    end else if (ext_en && (f <= LIT_OFFSET_MAX)) begin
      resolve_addr = ADDR_W'(base + ADDR_W'(f));
    end else begin
      resolve_addr = (f < ACCESS_SPLIT) ? ADDR_W'({ACCESS_LOW_BANK, f})
                                        : ADDR_W'({ACCESS_HIGH_BANK, f});
    end
  endfunction

  // relative target from the instruction's own address
  function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                     input logic [7:0] n);
    logic [PC_W-1:0] off;
    off = PC_W'({{(PC_W-8){n[7]}}, n}) <<< 1;
    branch_target = PC_W'(pc + PC_W'(BRANCH_STEP) + off);
  endfunction

  // ------------------------------------------------------------
  // phase source
  // ------------------------------------------------------------
  phase_gen i_phase_gen (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .o_phase(phase)
  );

  // ------------------------------------------------------------
  // execute state: next values
  // ------------------------------------------------------------
  // decode at Q1, condition at Q2, modify at Q3, commit at Q4
  always_comb begin
    kind_nxt = kind_r;
    instr_nxt = instr_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    target_nxt = target_r;
    taken_nxt = taken_r;
    nop_nxt = nop_r;
    unique case (phase)
      PH_Q1: begin
        taken_nxt = 1'b0;
        kind_nxt = K_NONE;
        // second cycle of a taken branch drops the fetched word
        if (!nop_r && i_instr_valid) begin
          instr_nxt = i_instr;
          addr_nxt = resolve_addr(i_instr, i_bank_select_register, i_ext_set_en,
                                  i_index_base);
          target_nxt = branch_target(i_instr_pc, i_instr[7:0]);
          if (i_instr[15:12] == OPC_BIT_CLEAR) begin
            kind_nxt = K_CLEAR;
          end else if (i_instr[15:8] == OPC_BRANCH_NEG) begin
            kind_nxt = K_NEG;
          end else if (i_instr[15:8] == OPC_BRANCH_NO_CARRY) begin
            kind_nxt = K_NO_CARRY;
          end
        end
      end
      PH_Q2: begin
        // jump on negative set or on carry clear; flags are only read, never written
        taken_nxt = ((kind_r == K_NEG) && i_negative) ||
                    ((kind_r == K_NO_CARRY) && !i_carry);
      end
      PH_Q3: begin
        if (kind_r == K_CLEAR) begin
          wdata_nxt = i_mem_rdata & ~(8'h01 << instr_r[BIT_SEL_LSB +: 3]);
        end
      end
      PH_Q4: begin
        // a taken branch costs one extra cycle
        nop_nxt = taken_r;
      end
    endcase
  end

  // execute state registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      kind_r <= K_NONE;
      instr_r <= INSTR_RST;
      addr_r <= '0;
      wdata_r <= DATA_RST;
      target_r <= '0;
      taken_r <= 1'b0;
      nop_r <= 1'b0;
    end else begin
      kind_r <= kind_nxt;
      instr_r <= instr_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      target_r <= target_nxt;
      taken_r <= taken_nxt;
      nop_r <= nop_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // handshakes decoded from phase; data held in flops
  assign o_instr_ready = (phase == PH_Q1) && !nop_r;
  assign o_discard = (phase == PH_Q1) && nop_r;
  // read in Q2, write back in Q4 of the same cycle
  assign o_mem_rd = (phase == PH_Q2) && (kind_r == K_CLEAR);
  assign o_mem_wr = (phase == PH_Q4) && (kind_r == K_CLEAR);
  assign o_mem_addr = addr_r;
  assign o_mem_wdata = wdata_r;
  // counter written in Q4 only when the branch is taken
  assign o_pc_load = (phase == PH_Q4) && taken_r;
  assign o_pc_target = target_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_clear_one_bit: assert property (
    (phase == PH_Q3 && kind_r == K_CLEAR) |=>
      o_mem_wdata == ($past(i_mem_rdata) & ~(8'h01 << instr_r[BIT_SEL_LSB +: 3])))
    else $error("bit clear wrote wrong data");

  chk_access_bank_addr: assert property (
    (o_mem_rd && !instr_r[ACCESS_BIT_POS] &&
     !($past(i_ext_set_en) && instr_r[7:0] <= LIT_OFFSET_MAX)) |->
      o_mem_addr[7:0] == instr_r[7:0] &&
      o_mem_addr[ADDR_W-1:8] == ((instr_r[7:0] < ACCESS_SPLIT) ? ACCESS_LOW_BANK
                                                               : ACCESS_HIGH_BANK))
    else $error("access bank address wrong");

  chk_banked_addr: assert property (
    (o_mem_rd && instr_r[ACCESS_BIT_POS]) |->
      o_mem_addr == ADDR_W'({$past(i_bank_select_register), instr_r[7:0]}))
    else $error("banked address wrong");

  chk_literal_offset: assert property (
    (o_mem_rd && !instr_r[ACCESS_BIT_POS] && $past(i_ext_set_en) &&
     instr_r[7:0] <= LIT_OFFSET_MAX) |->
      o_mem_addr == ADDR_W'($past(i_index_base) + ADDR_W'(instr_r[7:0])))
    else $error("indexed literal offset address wrong");

  chk_neg_decision: assert property (
    (phase == PH_Q2 && kind_r == K_NEG) |=> ##1 (o_pc_load == $past(i_negative, 2)))
    else $error("negative branch decision wrong");

  chk_no_carry_decision: assert property (
    (phase == PH_Q2 && kind_r == K_NO_CARRY) |=> ##1 (o_pc_load == !$past(i_carry, 2)))
    else $error("no-carry branch decision wrong");

  chk_branch_target: assert property (
    (o_instr_ready && i_instr_valid &&
     (i_instr[15:8] == OPC_BRANCH_NEG || i_instr[15:8] == OPC_BRANCH_NO_CARRY)) |->
      ##3 (!o_pc_load || o_pc_target == branch_target($past(i_instr_pc, 3),
                                                      $past(i_instr[7:0], 3))))
    else $error("branch target wrong");

  chk_taken_nop_cycle: assert property (
    o_pc_load |=> (o_discard && !o_instr_ready) ##1
      (!o_mem_rd && !o_mem_wr && !o_pc_load)[*3] ##1 o_instr_ready)
    else $error("taken branch second cycle not idle");

  chk_clear_sequence: assert property (
    (o_instr_ready && i_instr_valid && i_instr[15:12] == OPC_BIT_CLEAR) |=>
      o_mem_rd ##1 !o_mem_wr ##1 (o_mem_wr && !o_pc_load) ##1 o_instr_ready)
    else $error("bit clear phases out of order");

endmodule

// ===== core_exec_pkg.sv
/*
  Shared constants for the bit-clear and conditional-branch execute slice.
  Assumes one core clock where each clock is one phase of the four-phase
  instruction cycle.
*/
package core_exec_pkg;

  // ------------------------------------------------------------
  // opcode patterns
  // ------------------------------------------------------------
  localparam logic [3:0] OPC_BIT_CLEAR = 4'h9;        // top nibble of bit_clear_op
  localparam logic [7:0] OPC_BRANCH_NEG = 8'hE6;      // upper byte of branch_on_negative_op
  localparam logic [7:0] OPC_BRANCH_NO_CARRY = 8'hE3; // upper byte of branch_on_no_carry_op

  // ------------------------------------------------------------
  // field positions within the instruction word
  // ------------------------------------------------------------
  localparam int BIT_SEL_LSB = 9;
  localparam int ACCESS_BIT_POS = 8;

  // ------------------------------------------------------------
  // data address resolution
  // ------------------------------------------------------------
  localparam logic [7:0] LIT_OFFSET_MAX = 8'h5F;      // highest literal offset
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;        // access bank low/high split
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // ------------------------------------------------------------
  // branch arithmetic, phases and reset values
  // ------------------------------------------------------------
  localparam int BRANCH_STEP = 2;                     // counter already past the branch
  localparam int PHASE_COUNT = 4;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;

  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_type;
  typedef enum logic [1:0] {K_NONE, K_CLEAR, K_NEG, K_NO_CARRY} kind_type;

endpackage

// ===== phase_gen.sv
/*
  Four-phase generator: steps Q1..Q4 once per clock.
  Assumes a synchronous active-high reset; Q1 is the first phase after it.
*/
`timescale 1ns/1ns
module phase_gen
  import core_exec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  output phase_type o_phase
);

  phase_type phase_r;
  phase_type phase_nxt;

  // ------------------------------------------------------------
  // phase sequence
  // ------------------------------------------------------------
  // next phase wraps from Q4 back to Q1
  always_comb begin
    unique case (phase_r)
      PH_Q1: phase_nxt = PH_Q2;
      PH_Q2: phase_nxt = PH_Q3;
      PH_Q3: phase_nxt = PH_Q4;
      PH_Q4: phase_nxt = PH_Q1;
    endcase
  end

  // phase register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      phase_r <= PH_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign o_phase = phase_r;

endmodule

// ===== tb_bit_clear_cond_branch_exec.sv
/*
  Self-checking bench for the bit clear and conditional branch execute slice.
  Assumes the design's own assertions sit in its files and one 125 MHz clock.
*/
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_bit_clear_cond_branch_exec;
  import core_exec_pkg::*;
  localparam int PC_W = 21;
  localparam int ADDR_W = 12;
  logic i_clk, i_rst, i_instr_valid, i_ext_set_en, i_negative, i_carry;
  logic [15:0] i_instr;
  logic [PC_W-1:0] i_instr_pc;
  logic [3:0] i_bank_select_register;
  logic [ADDR_W-1:0] i_index_base;
  logic [7:0] i_mem_rdata;
  logic o_instr_ready, o_discard, o_mem_rd, o_mem_wr, o_pc_load;
  logic [ADDR_W-1:0] o_mem_addr;
  logic [7:0] o_mem_wdata;
  logic [PC_W-1:0] o_pc_target;
  int fails, checked;
  logic [31:0] seed, r, s;

  bit_clear_cond_branch_exec #(.PC_W(PC_W), .ADDR_W(ADDR_W)) i_bit_clear_cond_branch_exec (
    .i_clk(i_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
    .i_instr_pc(i_instr_pc), .i_bank_select_register(i_bank_select_register),
    .i_ext_set_en(i_ext_set_en), .i_index_base(i_index_base), .i_negative(i_negative),
    .i_carry(i_carry), .i_mem_rdata(i_mem_rdata), .o_instr_ready(o_instr_ready),
    .o_discard(o_discard), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_pc_load(o_pc_load),
    .o_pc_target(o_pc_target));

  // ------------------------------------------------------------
  // expectation helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // low offsets go indexed only with the extended set and access bit clear
  function automatic logic [ADDR_W-1:0] exp_addr(logic [7:0] f, logic a, logic [3:0] bk,
                                                 logic ext, logic [ADDR_W-1:0] bs);
    if (a) return {bk, f};
    if (ext && f <= LIT_OFFSET_MAX) return bs + ADDR_W'(f);
    return {((f < ACCESS_SPLIT) ? ACCESS_LOW_BANK : ACCESS_HIGH_BANK), f};
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // one instruction cycle, back to back with the next call
  // ------------------------------------------------------------
  task automatic run(input logic [15:0] w, input logic [PC_W-1:0] pc, input logic [3:0] bk,
                     input logic ext, input logic [ADDR_W-1:0] bs, input logic ng,
                     input logic cy, input logic [7:0] rd);
    logic clr, tk;
    logic [PC_W-1:0] tgt;
    int k;
    clr = (w[15:12] == OPC_BIT_CLEAR);
    // target wraps at the counter width, like the real counter
    tgt = PC_W'(pc + 2 + {{(PC_W-9){w[7]}}, w[7:0], 1'b0});
    tk = (w[15:8] == OPC_BRANCH_NEG && ng) || (w[15:8] == OPC_BRANCH_NO_CARRY && !cy);
    i_instr_valid = 1'b1;
    i_instr = w;
    i_instr_pc = pc;
    i_bank_select_register = bk;
    i_ext_set_en = ext;
    i_index_base = bs;
    i_negative = ng;
    i_carry = cy;
    k = 0;
    while (o_instr_ready !== 1'b1 && k < 16) begin
      @(posedge i_clk);
      #1;
      k++;
    end
    if (k == 16) begin
      fails++;
      stop_test();
    end
    @(posedge i_clk);
    #1;
    i_instr_valid = 1'b0;
    i_mem_rdata = rd;
    `CHK("mem_rd", clr, o_mem_rd)
    `CHK("pc_load_q2", 1'b0, o_pc_load)
    if (clr) `CHK("mem_addr", exp_addr(w[7:0], w[8], bk, ext, bs), o_mem_addr)
    repeat (2) @(posedge i_clk);
    #1;
    i_mem_rdata = ~rd;
    `CHK("mem_wr", clr, o_mem_wr)
    if (clr) `CHK("mem_wdata", rd & ~(8'h01 << w[11:9]), o_mem_wdata)
    `CHK("pc_load", tk, o_pc_load)
    if (tk) `CHK("pc_target", tgt, o_pc_target)
    @(posedge i_clk);
    #1;
    `CHK("discard", tk, o_discard)
    `CHK("ready", !tk, o_instr_ready)
  endtask

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'hC6B7;
    fails = 0;
    checked = 0;
    {i_rst, i_instr_valid, i_ext_set_en, i_negative, i_carry} = 5'h10;
    {i_instr, i_instr_pc, i_bank_select_register, i_index_base, i_mem_rdata} = '0;
    repeat (4) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    run({OPC_BIT_CLEAR, 3'h7, 1'b0, 8'h7F}, 21'h000100, 4'h3, 1'b0, 12'hFF0, 1'b0, 1'b1, 8'hC7);
    run({OPC_BIT_CLEAR, 3'h0, 1'b0, 8'h80}, 21'h000102, 4'h3, 1'b1, 12'hFF0, 1'b0, 1'b1, 8'hFF);
    run({OPC_BIT_CLEAR, 3'h3, 1'b1, 8'h10}, 21'h000104, 4'h5, 1'b1, 12'h000, 1'b1, 1'b0, 8'hFF);
    run({OPC_BIT_CLEAR, 3'h5, 1'b0, 8'h5F}, 21'h000106, 4'h2, 1'b1, 12'hFF0, 1'b0, 1'b0, 8'h20);
    run({OPC_BIT_CLEAR, 3'h1, 1'b0, 8'h60}, 21'h000108, 4'h2, 1'b1, 12'hFF0, 1'b0, 1'b0, 8'h02);
    run(16'h0000, 21'h00010A, 4'h1, 1'b0, 12'h000, 1'b1, 1'b0, 8'h55);
    $display("test corner done");
    // each flag value, extreme offsets, counter wrap
    for (int i = 0; i < 8; i++) begin
      run({(i[0] ? OPC_BRANCH_NEG : OPC_BRANCH_NO_CARRY), (i[2] ? 8'h80 : 8'h7F)},
          21'h1FFFF0 + PC_W'(2 * i), 4'h0, 1'b0, 12'h000, i[1], i[1], 8'h00);
    end
    $display("test branch done");
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      s = rnd();
      case (r[1:0])
        2'h0: run({OPC_BIT_CLEAR, r[15:4]}, {s[20:1], 1'b0}, s[24:21], r[2], s[11:0],
                  r[3], r[15], s[31:24]);
        2'h1: run({OPC_BRANCH_NEG, r[15:8]}, {s[20:1], 1'b0}, s[24:21], r[2], s[11:0],
                  r[3], r[16], s[31:24]);
        2'h2: run({OPC_BRANCH_NO_CARRY, r[15:8]}, {s[20:1], 1'b0}, s[24:21], r[2], s[11:0],
                  r[3], r[16], s[31:24]);
        default: run(r[31:16], {s[20:1], 1'b0}, s[24:21], r[2], s[11:0], r[3], r[16], s[31:24]);
      endcase
    end
    $display("test random done");
    stop_test();
  end
endmodule
